// *** dcsc_top.sv ***
// dcsc_top.sv: serial framing, channel select and result shifting of the
// two-input 12-bit converter, with status handed to the system clock
// assumes: cs_n and link_sclk come from the host; din is driven by the host
// on its own falling sclk edges, so it is synchronous to link_sclk
//
// Function
// - simultaneous cs and sclk fall: next rising edge captures first bit
// - first frame after power-up already yields a full valid conversion
// - channel selection starts at the first input after reset
// - channel select field sits at control bits 5 down to 3
// - control bits 7, 6, 2, 1, 0 have no effect
// - low select bits 00 pick first input, 01 second; top bit ignored
// - result is a 12-bit straight binary code
// - powered while cs low except between conversions, powered down while cs high
// - powered down from 16th falling edge to next conversion's first
// - back-to-back 16-clock conversions while cs stays low
// - control word captured on first 8 rising edges of each conversion
// - track 3 cycles, then result shifted MSB first from 5th clock
// - serial output floats while cs high, driven while cs low
`default_nettype none
`include "dcsc_cfg.svh"

module dcsc_top #(
  parameter int unsigned REFRESH = `DCSC_REFRESH
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire dcsc_pkg::dcsc_code_t analog_input_first,
  input  wire dcsc_pkg::dcsc_code_t analog_input_second,
  input  wire logic                 link_sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  output logic                      dout_o,
  output logic                      dout_oe,
  output logic                      conv_done,
  output dcsc_pkg::dcsc_code_t      conv_result,
  output dcsc_pkg::dcsc_ch_t        conv_chan,
  output logic                      dev_powered
);
  import dcsc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic dcsc_code_t pick_code(input logic bad, input dcsc_ch_t ch,
                                           input dcsc_code_t c1, input dcsc_code_t c2);
    if (bad) begin
      pick_code = `DCSC_BAD_CODE;
    end else if (ch == DCSC_CH_FIRST) begin
      pick_code = c1;
    end else begin
      pick_code = c2;
    end
  endfunction

  // ----------------------------------------------------------------
  // snapshot source on sys_clk
  // ----------------------------------------------------------------
  dcsc_snap_if snap_bus ();

  dcsc_snap #(
    .REFRESH (REFRESH)
  ) u_snap (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .analog_input_first  (analog_input_first),
    .analog_input_second (analog_input_second),
    .snap                (snap_bus.src)
  );

  // ----------------------------------------------------------------
  // link side reset
  // ----------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_r;

  always_ff @(posedge link_sclk) begin
    lrst_s1_r <= srst;
    lrst_r    <= lrst_s1_r;
  end

  // ----------------------------------------------------------------
  // snapshot crossing into link domain
  // ----------------------------------------------------------------
  logic snp_s1_r;
  logic snp_s2_r;

  // synced toggle names the finished copy; it is rewritten only two
  // refreshes later, so it is safe to read right after sclk restarts
  always_ff @(posedge link_sclk) begin
    if (lrst_r) begin
      snp_s1_r <= 1'b0;
      snp_s2_r <= 1'b0;
    end else begin
      snp_s1_r <= snap_bus.tgl;
      snp_s2_r <= snp_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // frame counter, cleared by cs_n high
  // ----------------------------------------------------------------
  dcsc_cnt_t edge_cnt_r;
  logic      wrap_r;

  // counts rising edges only, so a cs fall together with sclk fall
  // leaves the next rising edge as edge one
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_r <= '0;
    end else begin
      edge_cnt_r <= edge_cnt_r + `DCSC_CNT_W'(1);
    end
  end

  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= (edge_cnt_r == `DCSC_LAST_EDGE);
    end
  end

  // ----------------------------------------------------------------
  // control word capture
  // ----------------------------------------------------------------
  dcsc_ctrl_t ctrl_sh_r;
  dcsc_ctrl_t ctrl_word;
  logic       word_done;

  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      ctrl_sh_r <= '0;
    end else if (edge_cnt_r <= `DCSC_CTRL_LAST) begin
      ctrl_sh_r <= {ctrl_sh_r[`DCSC_CTRL_W-2:0], din};
    end
  end

  assign ctrl_word = {ctrl_sh_r[`DCSC_CTRL_W-2:0], din};
  assign word_done = (edge_cnt_r == `DCSC_CTRL_LAST);

  // ----------------------------------------------------------------
  // channel selection, held across frames
  // ----------------------------------------------------------------
  dcsc_ch_t chan_r;
  logic     sel_bad_r;

  // top and don't-care bits are never looked at
  always_ff @(posedge link_sclk) begin
    if (lrst_r) begin
      chan_r    <= DCSC_CH_FIRST;
      sel_bad_r <= 1'b0;
    end else if (word_done) begin
      sel_bad_r <= ctrl_word[`DCSC_SEL_MID];
      chan_r    <= ctrl_word[`DCSC_SEL_LOW] ? DCSC_CH_SECOND : DCSC_CH_FIRST;
    end
  end

  // ----------------------------------------------------------------
  // sample and result
  // ----------------------------------------------------------------
  dcsc_code_t result_r;
  dcsc_ch_t   res_chan_r;
  logic       conv_tgl_r;

  // hold at the end of tracking uses the selection made by an earlier word
  always_ff @(posedge link_sclk) begin
    if (lrst_r) begin
      result_r   <= '0;
      res_chan_r <= DCSC_CH_FIRST;
    end else if (!cs_n && edge_cnt_r == `DCSC_SAMPLE_EDGE) begin
      result_r   <= pick_code(sel_bad_r, chan_r, snap_bus.code_first[snp_s2_r],
                              snap_bus.code_second[snp_s2_r]);
      res_chan_r <= chan_r;
    end
  end

  always_ff @(posedge link_sclk) begin
    if (lrst_r) begin
      conv_tgl_r <= 1'b0;
    end else if (!cs_n && edge_cnt_r == `DCSC_LAST_EDGE) begin
      conv_tgl_r <= ~conv_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // output shifting and power-down on falling edges
  // ----------------------------------------------------------------
  logic dout_r;
  logic pd_r;

  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      dout_r <= 1'b0;
    end else if (edge_cnt_r >= `DCSC_MSB_EDGE) begin
      dout_r <= result_r[`DCSC_LAST_EDGE - edge_cnt_r];
    end else begin
      dout_r <= 1'b0;
    end
  end

  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= wrap_r;
    end
  end

  assign dout_o  = dout_r;
  assign dout_oe = ~cs_n;

  // ----------------------------------------------------------------
  // status into sys_clk domain
  // ----------------------------------------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic pd_s1_r;
  logic pd_s2_r;
  logic pw_r;
  logic cv_s1_r;
  logic cv_s2_r;
  logic cv_s3_r;
  logic done_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
      pw_r    <= 1'b0;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      pd_s1_r <= pd_r;
      pd_s2_r <= pd_s1_r;
      pw_r    <= ~cs_s2_r & ~pd_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cv_s1_r <= 1'b0;
      cv_s2_r <= 1'b0;
      cv_s3_r <= 1'b0;
    end else begin
      cv_s1_r <= conv_tgl_r;
      cv_s2_r <= cv_s1_r;
      cv_s3_r <= cv_s2_r;
    end
  end

  // result stands four sclk periods past the toggle, longer than the sync
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_result <= '0;
      conv_chan   <= DCSC_CH_FIRST;
      done_r      <= 1'b0;
    end else begin
      done_r <= (cv_s2_r != cv_s3_r);
      if (cv_s2_r != cv_s3_r) begin
        conv_result <= result_r;
        conv_chan   <= res_chan_r;
      end
    end
  end

  assign conv_done   = done_r;
  assign dev_powered = pw_r;
endmodule

`default_nettype wire

// *** dcsc_cfg.svh ***
// dcsc_cfg.svh: constants of the two-input converter serial control block
// assumes: included by the package and by the design files, by bare name
`ifndef DCSC_CFG_SVH
`define DCSC_CFG_SVH

`define DCSC_RES_W        12
`define DCSC_CTRL_W       8
`define DCSC_CNT_W        4
`define DCSC_SEL_TOP      5
`define DCSC_SEL_MID      4
`define DCSC_SEL_LOW      3
`define DCSC_CTRL_LAST    4'h7
`define DCSC_SAMPLE_EDGE  4'h3
`define DCSC_MSB_EDGE     4'h4
`define DCSC_LAST_EDGE    4'hF
`define DCSC_REFRESH      16
`define DCSC_BAD_CODE     12'h000

`endif

// *** dcsc_pkg.sv ***
// dcsc_pkg.sv: types of the converter serial control block
// assumes: dcsc_cfg.svh on the include path
`default_nettype none

package dcsc_pkg;
  `include "dcsc_cfg.svh"

  typedef logic [`DCSC_RES_W-1:0]  dcsc_code_t;
  typedef logic [`DCSC_CTRL_W-1:0] dcsc_ctrl_t;
  typedef logic [`DCSC_CNT_W-1:0]  dcsc_cnt_t;

  typedef enum logic {
    DCSC_CH_FIRST,
    DCSC_CH_SECOND
  } dcsc_ch_t;
endpackage

`default_nettype wire

// *** dcsc_snap_if.sv ***
// dcsc_snap_if.sv: carrier of the sample snapshot between the two modules
// assumes: dcsc_pkg compiled first
`default_nettype none

interface dcsc_snap_if;
  dcsc_pkg::dcsc_code_t [1:0] code_first;
  dcsc_pkg::dcsc_code_t [1:0] code_second;
  logic                       tgl;

  modport src (output code_first, output code_second, output tgl);
  modport dst (input code_first, input code_second, input tgl);
endinterface

`default_nettype wire

// *** dcsc_snap.sv ***
// dcsc_snap.sv: publishes two alternating held copies of both input codes with a toggle
// assumes: input codes are synchronous to sys_clk
`default_nettype none
`include "dcsc_cfg.svh"

module dcsc_snap #(
  parameter int unsigned REFRESH = `DCSC_REFRESH
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire dcsc_pkg::dcsc_code_t analog_input_first,
  input  wire dcsc_pkg::dcsc_code_t analog_input_second,
  dcsc_snap_if.src                  snap
);
  import dcsc_pkg::*;

  localparam int unsigned CW = (REFRESH > 1) ? $clog2(REFRESH) : 1;

  logic [CW-1:0] cnt_r;
  logic          last;

  // ----------------------------------------------------------------
  // refresh pacing
  // ----------------------------------------------------------------
  // each copy stands two refresh periods, so the link side reads it safely
  // even when sclk was stopped across several refreshes
  assign last = (cnt_r == CW'(REFRESH - 1));

  always_ff @(posedge sys_clk) begin
    if (srst || last) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      snap.code_first  <= '0;
      snap.code_second <= '0;
      snap.tgl         <= 1'b0;
    end else if (last) begin
      snap.code_first[~snap.tgl]  <= analog_input_first;
      snap.code_second[~snap.tgl] <= analog_input_second;
      snap.tgl                    <= ~snap.tgl;
    end
  end
endmodule

`default_nettype wire

// *** dcsc_checker.sv ***
// dcsc_checker.sv: port timing checks of the converter serial control block
// assumes: bound to dcsc_top; dcsc_pkg compiled first
`default_nettype none

module dcsc_checker #(
  parameter int unsigned REFRESH = 16
) (
  input wire logic                 sys_clk,
  input wire logic                 srst,
  input wire logic                 link_sclk,
  input wire logic                 cs_n,
  input wire logic                 din,
  input wire logic                 dout_o,
  input wire logic                 dout_oe,
  input wire logic                 conv_done,
  input wire dcsc_pkg::dcsc_code_t conv_result,
  input wire dcsc_pkg::dcsc_ch_t   conv_chan,
  input wire logic                 dev_powered
);
  timeunit 1ns;
  timeprecision 100ps;
  import dcsc_pkg::*;

  logic [3:0] edge_cnt;
  logic       mid_cur;
  logic       mid_sel;
  logic [3:0] lo_age;

  // rising edges seen in the current conversion
  always_ff @(posedge link_sclk or posedge cs_n)
    if (cs_n) edge_cnt <= 4'h0;
    else edge_cnt <= edge_cnt + 4'h1;

  // middle select bit, moved to the next conversion at its 16th edge
  always_ff @(posedge link_sclk) begin
    if (srst) begin
      mid_cur <= 1'b0;
      mid_sel <= 1'b0;
    end else if (!cs_n && edge_cnt == 4'h3) mid_cur <= din;
    else if (!cs_n && edge_cnt == 4'hF) mid_sel <= mid_cur;
  end

  always_ff @(posedge sys_clk)
    if (srst || !dev_powered) lo_age <= 4'h0;
    else if (lo_age != 4'hF) lo_age <= lo_age + 4'h1;

  property p_oe;
    @(posedge sys_clk) disable iff (srst) dout_oe == !cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable differs from chip select");
  property p_lead;
    @(posedge link_sclk) disable iff (srst || cs_n) edge_cnt < 4'h4 |-> !dout_o;
  endproperty
  a_lead: assert property (p_lead) else $error("output not low in the first four clocks");
  property p_mid;
    @(posedge link_sclk) disable iff (srst || cs_n) mid_sel |-> !dout_o;
  endproperty
  a_mid: assert property (p_mid) else $error("output not zero after a bad select");
  property p_space;
    @(posedge sys_clk) disable iff (srst) conv_done |=> !conv_done [*8];
  endproperty
  a_space: assert property (p_space) else $error("done pulses too close");
  property p_rst;
    @(posedge sys_clk) disable iff (srst)
      $fell(srst) |-> !conv_done && conv_result == 12'h000 && conv_chan == DCSC_CH_FIRST;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset");
  property p_hold;
    @(posedge sys_clk) disable iff (srst) !conv_done |-> $stable(conv_result) && $stable(conv_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without done");
  property p_off;
    @(posedge sys_clk) disable iff (srst) cs_n [*4] |-> !dev_powered;
  endproperty
  a_off: assert property (p_off) else $error("powered while deselected");
  property p_auto;
    @(posedge sys_clk) disable iff (srst) conv_done |-> (lo_age < 4'h8 or ##[0:4] !dev_powered);
  endproperty
  a_auto: assert property (p_auto) else $error("no power-down between conversions");

  c_done: cover property (@(posedge sys_clk) conv_done);
  c_mid: cover property (@(posedge link_sclk) mid_sel && !cs_n);
  c_b2b: cover property (@(posedge link_sclk) !cs_n && edge_cnt == 4'hF ##1 !cs_n);
endmodule

bind dcsc_top dcsc_checker #(.REFRESH(REFRESH)) dcsc_checker_i (
  .sys_clk(sys_clk), .srst(srst), .link_sclk(link_sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o),
  .dout_oe(dout_oe), .conv_done(conv_done), .conv_result(conv_result), .conv_chan(conv_chan),
  .dev_powered(dev_powered));

`default_nettype wire

// *** dcsc_host.sv ***
// dcsc_host.sv: host serial port model, chip select, 32 ns clock, control bits
// assumes: the bench calls run_clk during reset and frame for traffic
`default_nettype none

module dcsc_host (
  output logic      link_sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] rx [$];

  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  task automatic run_clk(input int n);
    repeat (n) begin
      #16 link_sclk = 1'b1;
      #16 link_sclk = 1'b0;
    end
  endtask

  // chip select and clock fall together; bits sampled just before each rise
  task automatic frame(input int edges, input logic [3:0][7:0] w);
    logic [15:0] sh;
    sh = 16'h0000;
    link_sclk = 1'b1;
    #16;
    cs_n = 1'b0;
    link_sclk = 1'b0;
    for (int k = 0; k < edges; k++) begin
      din = (k % 16 < 8) ? w[k / 16][7 - k % 16] : ~din;
      #16;
      sh = {sh[14:0], dout_o};
      if (k % 16 == 15) rx.push_back(sh);
      link_sclk = 1'b1;
      #16 link_sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// *** dual_channel_adc_serial_control_test.sv ***
// dual_channel_adc_serial_control_test.sv: self-checking bench of the converter block
// assumes: dcsc_host as far side, checker bound by its own file
`default_nettype none

module dual_channel_adc_serial_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dcsc_pkg::*;

  localparam int unsigned REFRESH = 16;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  dcsc_code_t  in_first = 12'hA5C;
  dcsc_code_t  in_second = 12'h3B7;
  wire         link_sclk;
  wire         cs_n;
  wire         din;
  wire         dout_o;
  wire         dout_oe;
  wire         dout_line;
  wire         conv_done;
  wire         dev_powered;
  dcsc_code_t  conv_result;
  dcsc_ch_t    conv_chan;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [12:0] seen [$];

  assign dout_line = dout_oe ? dout_o : 1'bz;
  always #10 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (conv_done === 1'b1) seen.push_back({conv_chan, conv_result});

  dcsc_top #(.REFRESH(REFRESH)) dcsc_top_i (
    .sys_clk(sys_clk), .srst(srst), .analog_input_first(in_first), .analog_input_second(in_second),
    .link_sclk(link_sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .conv_done(conv_done), .conv_result(conv_result), .conv_chan(conv_chan), .dev_powered(dev_powered));
  dcsc_host dcsc_host_i (.link_sclk(link_sclk), .cs_n(cs_n), .din(din), .dout_o(dout_line));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic run(input int edges, input logic [31:0] w);
    repeat (2 * REFRESH) @(negedge sys_clk);
    fork
      dcsc_host_i.frame(edges, w);
      begin
        repeat (8) @(negedge sys_clk);
        check({14'h0000, dev_powered, dout_oe}, 16'h0003);
      end
    join
    repeat (10) @(negedge sys_clk);
  endtask

  // serial word and reported status of the next conversion
  task automatic expect_conv(input dcsc_code_t code, input logic ch);
    logic [15:0] r;
    logic [12:0] g;
    r = {16{1'bx}};
    g = {13{1'bx}};
    if (dcsc_host_i.rx.size() > 0) r = dcsc_host_i.rx.pop_front();
    if (seen.size() > 0) g = seen.pop_front();
    check(r, {4'h0, code});
    check({3'h0, g}, {3'h0, ch, code});
  endtask

  initial begin
    fork
      begin
        repeat (6) @(negedge sys_clk);
        check(16'({conv_done, dev_powered, conv_chan, conv_result}), 16'h0000);
        srst = 1'b0;
      end
      dcsc_host_i.run_clk(12);
    join
    run(48, 32'h000820CF);
    expect_conv(12'hA5C, 1'b0);
    expect_conv(12'h3B7, 1'b1);
    expect_conv(12'hA5C, 1'b0);
    check({14'h0000, dev_powered, dout_oe}, 16'h0000);
    in_second = 12'h8E1;
    run(16, 32'h00000010);
    expect_conv(12'h8E1, 1'b1);
    run(16, 32'h00000000);
    expect_conv(12'h000, 1'b0);
    run(8, 32'h00000000);
    check(16'(seen.size() + dcsc_host_i.rx.size()), 16'h0000);
    in_first = 12'hFFF;
    run(16, 32'h00000000);
    expect_conv(12'hFFF, 1'b0);
    finish_test();
  end

  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
endmodule

`default_nettype wire
